// file: lcpc_core.sv
// Purpose: Lane enable and fault readout, driver configuration, phase-spread PWM lanes
// Assumes: scl_in and sda_in are synchronous to clk; dimming_input passes a two-flop synchronizer
// Notes:   Registers reached over the two-wire serial bus, slave only, no clock stretch
`timescale 1ns/1ps

module lcpc_core #(
   parameter int         PW        = 20,
   parameter logic [6:0] SLAVE_ADR = 7'h2C   // Arbitrary neutral address
) (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output      logic                    sda_out,
   output      logic                    sda_oe,
   input  wire logic                    dimming_input,
   input  wire logic [lcpc_pkg::LANES-1:0] lane_fault,
   output      logic [lcpc_pkg::LANES-1:0] lane_drive,
   output      logic                    duty_dc_mode,
   output      logic [7:0]              dc_level,
   output      lcpc_pkg::lcpc_strength_t boost_driver_strength,
   output      logic                    switch_rate_select,
   output      lcpc_pkg::lcpc_short_t   short_threshold,
   output      logic                    short_detect_en
);
   import lcpc_pkg::*;

   typedef struct packed {
      lcpc_bus_t        bus;
      logic [3:0]       bits;
      logic [7:0]       shift;
      logic [7:0]       ptr;
      logic             go_on;
      logic             sda_oe;
      logic             scl_q;
      logic             sda_q;
      logic [7:0]       cfg;
      logic [LANES-1:0] lanes;
      logic [7:0]       phase;
      logic [LANES-1:0] faulted;
      logic             din_s1;
      logic             din_s2;
      logic             din_q;
      logic [PW-1:0]    pos;
      logic [PW-1:0]    period;
      logic [PW-1:0]    high_len;
      logic [7:0]       dc_level;
      logic [LANES-1:0] drive;
   } lcpc_state_t;

   lcpc_state_t s_ff;
   lcpc_state_t nxt_s;

   logic             scl_rise;
   logic             scl_fall;
   logic             bus_start;
   logic             bus_stop;
   logic [7:0]       rd_data;
   logic [2:0]       n_en;
   logic [PW-1:0]    step;
   logic [31:0]      step_uni;
   logic [31:0]      step_man;
   logic [31:0]      step_dir;
   logic [7:0]       duty_calc;
   logic             stale;
   logic [LANES-1:0] lane_nxt;
   logic [SPREAD_W-1:0] spread;

   function automatic logic [2:0] lcpc_rank(input logic [LANES-1:0] en, input int k);
      logic [2:0] r;
      r = 3'd0;
      for (int i = 0; i < LANES; i++) begin
         if (i < k && en[i]) begin
            r = r + 3'd1;
         end
      end
      return r;
   endfunction : lcpc_rank

   assign scl_rise  = scl_in & ~s_ff.scl_q;
   assign scl_fall  = ~scl_in & s_ff.scl_q;
   assign bus_start = s_ff.scl_q & scl_in & s_ff.sda_q & ~sda_in;
   assign bus_stop  = s_ff.scl_q & scl_in & ~s_ff.sda_q & sda_in;

   // Register readback at the current pointer
   always_comb begin
      case (s_ff.ptr)
         REG_CONFIG_OFS: rd_data = s_ff.cfg;
         REG_LANE_OFS:   rd_data = {2'b00, s_ff.lanes & ~s_ff.faulted};
         REG_PHASE_OFS:  rd_data = s_ff.phase;
         default:        rd_data = 8'h00;
      endcase
   end

   // Delay step per enabled lane
   assign n_en     = lcpc_rank(s_ff.lanes, LANES);
   assign spread   = s_ff.phase[PH_SPREAD_LSB +: SPREAD_W];
   assign step_uni = 32'(s_ff.period) / ((n_en == 3'd0) ? 32'd1 : 32'(n_en));
   assign step_man = (32'(s_ff.period) * 32'(spread)) / 32'(MANUAL_DIVISOR);
   assign step_dir = (32'(spread) * 32'(CLK_FREQ_KHZ)) / 32'(TIMEBASE_KHZ);

   always_comb begin
      if (s_ff.cfg[CFG_DIRECT_BIT]) begin
         step = PW'(step_dir);
      end else if (s_ff.phase[PH_UNIFORM_BIT]) begin
         step = PW'(step_uni);
      end else begin
         step = PW'(step_man);
      end
   end

   // Duty of the period just ended, 0..255
   assign duty_calc = 8'((32'(s_ff.high_len) * 32'(DUTY_FULL_SCALE))
                         / (32'(s_ff.pos) + 32'd1));
   // No rising edge seen yet, or input held steady: lanes follow the input level
   assign stale     = (s_ff.pos >= s_ff.period);

   for (genvar k = 0; k < LANES; k++) begin : g_lane
      logic [2:0]    rank;
      logic [PW-1:0] dly;
      logic [PW-1:0] d;
      logic          win;
      logic          act;

      assign rank = lcpc_rank(s_ff.lanes, k);
      assign dly  = PW'(step * PW'(rank));
      assign d    = (s_ff.pos >= dly) ? PW'(s_ff.pos - dly)
                                      : PW'(s_ff.pos + s_ff.period - dly);
      assign win  = (d < s_ff.high_len);
      assign act  = s_ff.lanes[k] & ~s_ff.faulted[k];

      always_comb begin
         if (!act) begin
            lane_nxt[k] = 1'b0;
         end else if (s_ff.cfg[CFG_DUTY_DC_BIT]) begin
            lane_nxt[k] = 1'b1;
         end else if (stale || (s_ff.cfg[CFG_DIRECT_BIT] && dly == '0)) begin
            lane_nxt[k] = s_ff.din_s2;
         end else begin
            lane_nxt[k] = win;
         end
      end
   end

   always_comb begin
      logic [LANES-1:0] lane_clr;
      lane_clr = '0;
      nxt_s    = s_ff;

      nxt_s.scl_q  = scl_in;
      nxt_s.sda_q  = sda_in;
      nxt_s.din_s1 = dimming_input;
      nxt_s.din_s2 = s_ff.din_s1;
      nxt_s.din_q  = s_ff.din_s2;

      // Serial slave
      if (bus_start) begin
         nxt_s.bus    = B_ADDR;
         nxt_s.bits   = 4'd0;
         nxt_s.sda_oe = 1'b0;
      end else if (bus_stop) begin
         nxt_s.bus    = B_IDLE;
         nxt_s.sda_oe = 1'b0;
      end else if (scl_rise) begin
         case (s_ff.bus)
            B_ADDR, B_CMD, B_WDATA: begin
               if (s_ff.bits != 4'd8) begin
                  nxt_s.shift = {s_ff.shift[6:0], sda_in};
                  nxt_s.bits  = s_ff.bits + 4'd1;
               end
            end
            B_RDATA: begin
               nxt_s.shift = {s_ff.shift[6:0], 1'b0};
               nxt_s.bits  = s_ff.bits + 4'd1;
            end
            B_RACK: nxt_s.go_on = ~sda_in;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (s_ff.bus)
            B_ADDR: begin
               if (s_ff.bits == 4'd8) begin
                  if (s_ff.shift[7:1] == SLAVE_ADR) begin
                     nxt_s.sda_oe = 1'b1;
                     nxt_s.go_on  = s_ff.shift[0];
                     nxt_s.bus    = B_AACK;
                  end else begin
                     nxt_s.bus = B_IDLE;
                  end
               end
            end
            B_AACK, B_RACK: begin
               nxt_s.bits = 4'd0;
               if (s_ff.go_on) begin
                  nxt_s.shift  = rd_data;
                  nxt_s.ptr    = s_ff.ptr + 8'd1;
                  nxt_s.sda_oe = ~rd_data[7];
                  nxt_s.bus    = B_RDATA;
               end else begin
                  nxt_s.sda_oe = 1'b0;
                  nxt_s.bus    = (s_ff.bus == B_AACK) ? B_CMD : B_IDLE;
               end
            end
            B_CMD: begin
               if (s_ff.bits == 4'd8) begin
                  nxt_s.ptr    = s_ff.shift;
                  nxt_s.sda_oe = 1'b1;
                  nxt_s.bus    = B_WACK;
               end
            end
            B_WDATA: begin
               if (s_ff.bits == 4'd8) begin
                  case (s_ff.ptr)
                     REG_CONFIG_OFS: nxt_s.cfg = s_ff.shift;
                     REG_LANE_OFS: begin
                        nxt_s.lanes = s_ff.shift[LANES-1:0];
                        lane_clr    = ~s_ff.shift[LANES-1:0];
                     end
                     REG_PHASE_OFS:  nxt_s.phase = s_ff.shift;
                     default: ;
                  endcase
                  nxt_s.ptr    = s_ff.ptr + 8'd1;
                  nxt_s.sda_oe = 1'b1;
                  nxt_s.bus    = B_WACK;
               end
            end
            B_WACK: begin
               nxt_s.sda_oe = 1'b0;
               nxt_s.bits   = 4'd0;
               nxt_s.bus    = B_WDATA;
            end
            B_RDATA: begin
               if (s_ff.bits == 4'd8) begin
                  nxt_s.sda_oe = 1'b0;
                  nxt_s.bus    = B_RACK;
               end else begin
                  nxt_s.sda_oe = ~s_ff.shift[7];
               end
            end
            default: ;
         endcase
      end

      // Fault latch: a new fault wins over a same-cycle clear
      nxt_s.faulted = (s_ff.faulted & ~lane_clr)
                    | (lane_fault & s_ff.lanes);

      // Dimming period and high-time measurement
      if (s_ff.din_s2 && !s_ff.din_q) begin
         nxt_s.period   = PW'(s_ff.pos + 1'b1);
         nxt_s.pos      = '0;
         nxt_s.dc_level = duty_calc;
      end else if (s_ff.pos != '1) begin
         nxt_s.pos = PW'(s_ff.pos + 1'b1);
      end
      if (!s_ff.din_s2 && s_ff.din_q) begin
         nxt_s.high_len = PW'(s_ff.pos + 1'b1);
      end

      nxt_s.drive = lane_nxt;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_ff       <= '0;
         s_ff.bus   <= B_IDLE;
         s_ff.cfg   <= CONFIG_RST;
         s_ff.lanes <= LANE_RST;
         s_ff.phase <= PHASE_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign sda_out               = 1'b0;
   assign sda_oe                = s_ff.sda_oe;
   assign lane_drive            = s_ff.drive;
   assign duty_dc_mode          = s_ff.cfg[CFG_DUTY_DC_BIT];
   assign dc_level              = s_ff.dc_level;
   assign boost_driver_strength = lcpc_strength_t'(s_ff.cfg[CFG_STRENGTH_LSB +: 2]);
   assign switch_rate_select    = s_ff.cfg[CFG_RATE_BIT];
   assign short_threshold       = lcpc_short_t'(s_ff.cfg[CFG_SHORT_LSB +: 2]);
   assign short_detect_en       = (s_ff.cfg[CFG_SHORT_LSB +: 2] != 2'b00);

endmodule : lcpc_core

// file: lcpc_pkg.sv
// Purpose: Shared constants and types for the LED lane phase control core
// Assumes: 8-bit registers on a two-wire serial bus; six output lanes
// Notes:   Register offsets and reset values are used by the core and the tests
package lcpc_pkg;

   // Register map
   localparam logic [7:0] REG_CONFIG_OFS   = 8'h08;
   localparam logic [7:0] REG_LANE_OFS     = 8'h09;
   localparam logic [7:0] REG_PHASE_OFS    = 8'h0A;

   // Reset values
   localparam logic [7:0] CONFIG_RST       = 8'h1F;
   localparam logic [5:0] LANE_RST         = 6'h3F;
   localparam logic [7:0] PHASE_RST        = 8'h00;

   // Configuration fields
   localparam int         CFG_DIRECT_BIT   = 6;
   localparam int         CFG_DUTY_DC_BIT  = 5;
   localparam int         CFG_STRENGTH_LSB = 3;
   localparam int         CFG_RATE_BIT     = 2;
   localparam int         CFG_SHORT_LSB    = 0;

   // Phase register fields
   localparam int         PH_UNIFORM_BIT   = 7;
   localparam int         PH_SPREAD_LSB    = 0;
   localparam int         SPREAD_W         = 7;

   localparam int         LANES            = 6;

   // Timing: core clock and the spread time base in direct-follow mode
   localparam int         CLK_FREQ_KHZ     = 10000;
   localparam int         TIMEBASE_KHZ     = 12800;
   localparam int         MANUAL_DIVISOR   = 255;
   localparam int         DUTY_FULL_SCALE  = 255;

   // Boost driver strength codes: 25, 50, 75, 100 percent
   typedef enum logic [1:0] {STRENGTH_25, STRENGTH_50, STRENGTH_75, STRENGTH_100} lcpc_strength_t;

   // Switching rate select: 0 is 1200 kHz, 1 is 600 kHz
   localparam logic       RATE_1200K       = 1'b0;
   localparam logic       RATE_600K        = 1'b1;

   // Short threshold codes: off, 3.6 V, 4.8 V, 5.8 V
   typedef enum logic [1:0] {SHORT_OFF, SHORT_3V6, SHORT_4V8, SHORT_5V8} lcpc_short_t;

   // Serial slave sequencer
   typedef enum logic [3:0] {
      B_IDLE, B_ADDR, B_AACK, B_CMD, B_WDATA, B_WACK, B_RDATA, B_RACK
   } lcpc_bus_t;

endpackage : lcpc_pkg

// file: lcpc_core_properties.sv
// Purpose: Port checks for the lane phase control core
// Assumes: One clk domain, sys_rst async active high
// Notes:   Bound to every core instance
`timescale 1ns/1ps
module lcpc_core_chk (
   input wire logic                         clk,
   input wire logic                         sys_rst,
   input wire logic                         scl_in,
   input wire logic                         sda_in,
   input wire logic                         sda_out,
   input wire logic                         sda_oe,
   input wire logic                         dimming_input,
   input wire logic [lcpc_pkg::LANES-1:0]   lane_fault,
   input wire logic [lcpc_pkg::LANES-1:0]   lane_drive,
   input wire logic                         duty_dc_mode,
   input wire logic [7:0]                   dc_level,
   input wire lcpc_pkg::lcpc_strength_t     boost_driver_strength,
   input wire logic                         switch_rate_select,
   input wire lcpc_pkg::lcpc_short_t        short_threshold,
   input wire logic                         short_detect_en
);
   import lcpc_pkg::*;
   logic [6:0] dim_hist_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) dim_hist_ff <= '0;
      else dim_hist_ff <= {dim_hist_ff[5:0], dimming_input};
   end
   AST_RST_LANES: assert property (disable iff (1'b0)
      sys_rst && $past(sys_rst) |-> lane_drive == '0) else $error("lanes on in reset");
   AST_RST_CFG: assert property (disable iff (1'b0)
      sys_rst && $past(sys_rst) |-> boost_driver_strength == STRENGTH_100 &&
      switch_rate_select == RATE_600K && short_threshold == SHORT_5V8 && !duty_dc_mode)
      else $error("config reset value wrong");
   AST_SDA_LOW: assert property (sda_out == 1'b0)
      else $error("sda_out not low");
   AST_OE_AFTER_FALL: assert property ($changed(sda_oe) |->
      !$past(scl_in) && ($past(scl_in, 2) || $past(scl_in, 3)))
      else $error("sda_oe moved outside scl low");
   AST_CFG_ON_WRITE: assert property ($changed({boost_driver_strength,
      switch_rate_select, short_threshold, duty_dc_mode}) |-> !$past(scl_in) ||
      !$past(scl_in, 2)) else $error("config moved without write");
   AST_SHORT_EN: assert property (short_detect_en == (short_threshold != SHORT_OFF))
      else $error("short enable mismatch");
   AST_FAULT_DARK: assert property ((lane_drive & lane_fault & $past(lane_fault) &
      $past(lane_fault, 2) & $past(lane_fault, 3)) == '0) else $error("faulted lane driven");
   AST_DCLVL_ON_RISE: assert property ($changed(dc_level) |->
      |(dim_hist_ff[5:0] & ~dim_hist_ff[6:1])) else $error("dc level moved off rise");
   AST_DC_STEADY: assert property (duty_dc_mode && $past(duty_dc_mode, 5) && scl_in &&
      $past(scl_in) && $past(scl_in, 2) && !(|(lane_fault | $past(lane_fault) |
      $past(lane_fault, 2) | $past(lane_fault, 3))) |-> $stable(lane_drive))
      else $error("dc lanes pulsed");
   COV_ACK: cover property ($rose(sda_oe));
   COV_DC: cover property (duty_dc_mode && lane_drive != '0);
   COV_FAULT: cover property (lane_fault != '0 ##1 lane_fault == '0);
endmodule : lcpc_core_chk
bind lcpc_core lcpc_core_chk u_chk (.clk(clk), .sys_rst(sys_rst), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .dimming_input(dimming_input),
   .lane_fault(lane_fault), .lane_drive(lane_drive), .duty_dc_mode(duty_dc_mode),
   .dc_level(dc_level), .boost_driver_strength(boost_driver_strength),
   .switch_rate_select(switch_rate_select), .short_threshold(short_threshold),
   .short_detect_en(short_detect_en));

// file: lcpc_dim_src.sv
// Purpose: Free running dimming source
// Assumes: Output moves 1 ns after rising clk
// Notes:   Period and high time in clk cycles
`timescale 1ns/1ps
module lcpc_dim_src #(
   parameter int PERIOD = 80,
   parameter int HIGH   = 20
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   output      logic dimming_input
);
   int cnt;
   initial dimming_input = 1'b0;
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt = 0;
         dimming_input <= #1 1'b0;
      end else begin
         cnt = (cnt + 1) % PERIOD;
         dimming_input <= #1 (cnt < HIGH);
      end
   end
endmodule : lcpc_dim_src

// file: tb_top.sv
// Purpose: Register and lane tests for the core
// Assumes: Bus driven by tasks, SCL half period 4 clk
// Notes:   Inputs move 1 ns after rising clk
`timescale 1ns/1ps
module tb_top;
   import lcpc_pkg::*;
   localparam logic [6:0] ADR = 7'h2C;  // Arbitrary
   logic           clk = 0, sys_rst = 1, scl = 1, sda_h = 1;
   logic           sda_oe, dim, dc_mode, rate, short_en;
   logic [5:0]     lane_fault = '0, lane_drive;
   logic [7:0]     dc_level;
   logic [2:0]     k;
   lcpc_strength_t strength;
   lcpc_short_t    shrt;
   wire            sda_w = sda_h & ~sda_oe;
   int             error_cnt = 0, checked = 0;
   logic [7:0]     t_cfg [5] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h20};
   logic [7:0]     t_ph  [5] = '{8'h00, 8'h08, 8'h33, 8'h80, 8'h00};
   int             t_off [5] = '{12, 12, 28, 40, 40};
   logic [7:0]     t_exp [5] = '{8'h07, 8'h03, 8'h02, 8'h02, 8'h07};
   always #50 clk = ~clk;
   lcpc_dim_src dsrc (.clk(clk), .sys_rst(sys_rst), .dimming_input(dim));
   lcpc_core #(.SLAVE_ADR(ADR)) uut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
      .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .dimming_input(dim),
      .lane_fault(lane_fault), .lane_drive(lane_drive), .duty_dc_mode(dc_mode),
      .dc_level(dc_level), .boost_driver_strength(strength), .switch_rate_select(rate),
      .short_threshold(shrt), .short_detect_en(short_en));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic bitx(input logic b, output logic s);
      sda_h = b;
      tick(2);
      scl = 1;
      tick(2);
      s = sda_w;
      tick(2);
      scl = 0;
      tick(2);
   endtask : bitx
   // Start when a=1,b=0; stop when a=0,b=1
   task automatic cond(input logic a, input logic b);
      sda_h = a;
      tick(2);
      scl = 1;
      tick(4);
      sda_h = b;
      tick(4);
      if (!b) begin
         scl = 0;
         tick(2);
      end
   endtask : cond
   task automatic wbyte(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], a);
      bitx(1'b1, a);
      check(8'(a), 8'h00, "ack");
   endtask : wbyte
   task automatic wreg(input logic [7:0] ofs, input logic [7:0] v);
      cond(1, 0);
      wbyte({ADR, 1'b0});
      wbyte(ofs);
      wbyte(v);
      cond(0, 1);
   endtask : wreg
   task automatic rreg(input logic [7:0] ofs, input logic [7:0] exp, input string nm);
      logic       a;
      logic [7:0] d;
      cond(1, 0);
      wbyte({ADR, 1'b0});
      wbyte(ofs);
      cond(1, 0);
      wbyte({ADR, 1'b1});
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(1'b1, a);
      cond(0, 1);
      check(d, exp, nm);
   endtask : rreg
   task automatic close_out;
      if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : close_out
   initial begin
      #5_000_000;
      error_cnt++;
      close_out();
   end
   initial begin
      tick(10);
      sys_rst = 0;
      tick(4);
      rreg(REG_CONFIG_OFS, CONFIG_RST, "config");
      rreg(REG_LANE_OFS, {2'b00, LANE_RST}, "lanes");
      rreg(REG_PHASE_OFS, PHASE_RST, "phase");
      rreg(8'h20, 8'h00, "unmapped");
      for (k = 0; k < 4; k++) begin
         wreg(REG_CONFIG_OFS, {3'b000, k[1:0], k[0], k[1:0]});
         check(8'(strength), 8'(k[1:0]), "strength");
         check(8'(rate), 8'(k[0]), "rate");
         check(8'(shrt), 8'(k[1:0]), "short");
         check(8'(short_en), 8'(k != 3'h0), "short_en");
      end
      wreg(REG_LANE_OFS, 8'hC5);
      rreg(REG_LANE_OFS, 8'h05, "lane rsvd");
      wreg(REG_CONFIG_OFS, 8'h20);
      check(8'(lane_drive), 8'h05, "dc lanes");
      check(8'(dc_mode), 8'h01, "dc mode");
      wreg(REG_LANE_OFS, 8'h3F);
      lane_fault = 6'h04;
      tick(6);
      lane_fault = 6'h00;
      tick(4);
      check(8'(lane_drive), 8'h3B, "fault lanes");
      rreg(REG_LANE_OFS, 8'h3B, "fault read");
      wreg(REG_LANE_OFS, 8'h3B);
      wreg(REG_LANE_OFS, 8'h3F);
      rreg(REG_LANE_OFS, 8'h3F, "retry read");
      check(8'(lane_drive), 8'h3F, "retry lanes");
      wreg(REG_LANE_OFS, 8'h07);
      // Spread kept inside one period of 80 clk
      for (int r = 0; r < 5; r++) begin
         wreg(REG_CONFIG_OFS, t_cfg[r]);
         wreg(REG_PHASE_OFS, t_ph[r]);
         tick(240);
         @(posedge dim);
         tick(t_off[r]);
         check(8'(lane_drive), t_exp[r], "phase");
      end
      // Source duty 20 of 80 clk, scaled to 0..255
      check(dc_level, 8'(20 * DUTY_FULL_SCALE / 80), "dc level");
      close_out();
   end
endmodule : tb_top
